// *** logic/ttc_pkg.sv ***
// Package of the transmit template configuration bank: offsets, fields, resets.
// Assumes an 8-bit control port with the channel in address bits 7-6.
package ttc_pkg;

    localparam int NUM_CH = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CH_SHIFT = 6;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets within a channel
    localparam logic [5:0] OFF_DRV_TPL = 6'h03;
    localparam logic [5:0] OFF_AMP_SCALE = 6'h04;
    localparam logic [5:0] OFF_RAM_ACC = 6'h05;
    localparam logic [5:0] OFF_SAMPLE_AMP = 6'h06;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int DRIVER_FAULT_MONITOR_DISABLE_BIT = 5;
    localparam int TRISTATE_BIT = 4;
    localparam int TPL_LSB = 0;
    localparam int TPL_W = 4;
    localparam int SCALE_W = 6;
    localparam int LAUNCH_BIT = 7;
    localparam int DIR_BIT = 6;
    localparam int UI_LSB = 4;
    localparam int UI_W = 2;
    localparam int SAMP_LSB = 0;
    localparam int SAMP_W = 4;
    localparam int AMP_W = 7;
    localparam int RAM_AW = UI_W + SAMP_W;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic RST_DRIVER_FAULT_MONITOR_DISABLE = 1'b0;
    localparam logic RST_TRISTATE = 1'b1;
    localparam logic [3:0] RST_TPL = 4'h0;
    localparam logic [5:0] RST_SCALE = 6'h21;
    localparam logic [6:0] RST_AMP = 7'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Template codes and scale figures
    localparam logic [3:0] TPL_E1_75 = 4'h0;
    localparam logic [3:0] TPL_E1_120 = 4'h1;
    localparam logic [3:0] TPL_J1 = 4'h7;
    localparam logic [1:0] TPL_USER_TOP = 2'h3;
    localparam logic [5:0] SCALE_REC_T1 = 6'h36;
    localparam logic [5:0] SCALE_REC_E1 = 6'h21;
    localparam logic [1:0] STEP_PCT_T1 = 2'h2;
    localparam logic [1:0] STEP_PCT_E1 = 2'h3;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_RUN = 2'b01,
        ACC_FINISH = 2'b11
    } ttc_acc_state_t;

endpackage

// *** logic/ttc_acc_if.sv ***
// Interface joining the register bank to one channel's template access sequencer.
// Assumes one instance per channel, all on the bank clock.
`timescale 1ns/100ps
interface ttc_acc_if;
    import ttc_pkg::*;
    logic launch;
    logic dir_rd;
    logic [UI_W-1:0] ui;
    logic [SAMP_W-1:0] samp;
    logic [AMP_W-1:0] wr_amp;
    logic busy;
    logic rd_valid;
    logic [AMP_W-1:0] rd_amp;
    logic ram_we;
    logic ram_re;
    logic [RAM_AW-1:0] ram_addr;
    logic [AMP_W-1:0] ram_wdata;
    logic [AMP_W-1:0] ram_rdata;

    modport bank (output launch, dir_rd, ui, samp, wr_amp, ram_rdata,
                  input busy, rd_valid, rd_amp, ram_we, ram_re, ram_addr, ram_wdata);
    modport seq (input launch, dir_rd, ui, samp, wr_amp, ram_rdata,
                 output busy, rd_valid, rd_amp, ram_we, ram_re, ram_addr, ram_wdata);
endinterface

// *** logic/ttc_template_ram.sv ***
// Pulse template RAM of one channel: unit interval and sample form the address.
// Assumes at most one of write and read per cycle; read data lands one edge later.
`timescale 1ns/100ps
module ttc_template_ram #(
    parameter int AW = ttc_pkg::RAM_AW,
    parameter int DW = ttc_pkg::AMP_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic we_i,
    input wire logic re_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);
    import ttc_pkg::*;

    logic [DW-1:0] mem_q [2**AW];
    logic [DW-1:0] rdata_q;

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[addr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
        end else if (re_i) begin
            rdata_q <= mem_q[addr_i];
        end
    end

    assign rdata_o = rdata_q;

endmodule

// *** logic/ttc_access_seq.sv ***
// Sequencer for one indirect template RAM access per launch.
// Assumes the bank raises launch only while busy is low.
`timescale 1ns/100ps
module ttc_access_seq (
    input wire logic clk_i,
    input wire logic rst_n_i,
    ttc_acc_if.seq acc
);
    import ttc_pkg::*;

    ttc_acc_state_t state_q;
    logic dir_q;
    logic [RAM_AW-1:0] addr_q;
    logic [AMP_W-1:0] wdat_q;
    logic busy_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Snapshot of the access fields at launch
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_q <= 1'b0;
            addr_q <= '0;
            wdat_q <= '0;
        end else if (state_q == ACC_IDLE && acc.launch) begin
            dir_q <= acc.dir_rd;
            addr_q <= {acc.ui, acc.samp};
            wdat_q <= acc.wr_amp;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ACC_IDLE;
        end else begin
            unique case (state_q)
                ACC_IDLE: begin
                    if (acc.launch) begin
                        state_q <= ACC_RUN;
                    end
                end
                ACC_RUN: begin
                    state_q <= ACC_FINISH;
                end
                ACC_FINISH: begin
                    state_q <= ACC_IDLE;
                end
                default: begin
                    state_q <= ACC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_q <= 1'b0;
        end else if (state_q == ACC_IDLE && acc.launch) begin
            busy_q <= 1'b1;
        end else if (state_q == ACC_FINISH) begin
            busy_q <= 1'b0;
        end
    end

    assign acc.busy = busy_q;
    assign acc.ram_we = (state_q == ACC_RUN) && !dir_q;
    assign acc.ram_re = (state_q == ACC_RUN) && dir_q;
    assign acc.ram_addr = addr_q;
    assign acc.ram_wdata = wdat_q;
    assign acc.rd_valid = (state_q == ACC_FINISH) && dir_q;
    assign acc.rd_amp = acc.ram_rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    launch_runs_a: assert property (state_q == ACC_IDLE && acc.launch |=> state_q == ACC_RUN ##1 state_q == ACC_FINISH)
        else $error("launch did not run the access");
    dir_selects_a: assert property (state_q == ACC_IDLE && acc.launch |=> acc.ram_we == !$past(acc.dir_rd))
        else $error("RAM direction differs from launch");
    fields_held_a: assert property (state_q != ACC_IDLE |=> $stable(addr_q) && $stable(dir_q))
        else $error("access fields changed mid access");
    read_result_a: assert property (acc.ram_re |=> acc.rd_valid)
        else $error("read result not presented");

endmodule

// *** logic/ttc_tx_template_cfg.sv ***
// Transmit template configuration bank for all channels, on the control port.
// Assumes single-cycle write and read strobes synchronous to clk_i.
//
// Overview of operation
// - Driver fault monitor disable bit 5 of first register; zero keeps monitor active.
// - Bit 4 tristates only the line driver; resets to one.
// - Bits 3-0 pick template; 0-7 fixed, 8-11 reserved, 11xx user waveform.
// - Six-bit scaling field of second register scales user pulses; resets 100001.
// - T1 and J1 recommend scale 110110, each step about two percent.
// - E1 recommends scale 100001, each step about three percent.
// - Writing one to bit 7 of third register while not busy launches one RAM access.
// - Bit 6 picks direction: zero writes RAM, one reads it.
// - Bits 5-4 address one of four unit intervals, zero leftmost.
// - Bits 3-0 address one of sixteen samples, zero leftmost.
// - Indirect write loads the seven-bit amplitude register into the addressed sample.
// - Indirect read returns the addressed sample into the amplitude field.
`timescale 1ns/100ps
module ttc_tx_template_cfg #(
    parameter int NUM_CH = ttc_pkg::NUM_CH
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [ttc_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [ttc_pkg::DATA_W-1:0] reg_wdata_i,
    output logic [ttc_pkg::DATA_W-1:0] reg_rdata_o,
    output logic [NUM_CH-1:0] driver_fault_monitor_disable_o,
    output logic [NUM_CH-1:0] line_driver_tristate_o,
    output logic [NUM_CH-1:0][ttc_pkg::TPL_W-1:0] tx_template_select_o,
    output logic [NUM_CH-1:0] user_waveform_sel_o,
    output logic [NUM_CH-1:0][ttc_pkg::SCALE_W-1:0] pulse_amplitude_scale_o,
    output logic [NUM_CH-1:0][1:0] scale_step_pct_o,
    output logic [NUM_CH-1:0] access_busy_o
);
    import ttc_pkg::*;

    logic [1:0] ch_sel;
    logic [5:0] reg_idx;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    logic [NUM_CH-1:0] driver_fault_monitor_disable_q;
    logic [NUM_CH-1:0] tristate_q;
    logic [NUM_CH-1:0][TPL_W-1:0] tpl_q;
    logic [NUM_CH-1:0] user_q;
    logic [NUM_CH-1:0][1:0] step_q;
    logic [NUM_CH-1:0][SCALE_W-1:0] scale_q;
    logic [NUM_CH-1:0] dir_q;
    logic [NUM_CH-1:0][UI_W-1:0] ui_q;
    logic [NUM_CH-1:0][SAMP_W-1:0] samp_q;
    logic [NUM_CH-1:0][AMP_W-1:0] amp_q;
    logic [NUM_CH-1:0] busy;

    assign ch_sel = reg_addr_i[ADDR_W-1:CH_SHIFT];
    assign reg_idx = reg_addr_i[CH_SHIFT-1:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel registers, sequencer and RAM
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        logic hit;
        logic wr_tpl;
        logic wr_scale;
        logic wr_acc;
        logic wr_amp;
        ttc_acc_if acc ();

        assign hit = reg_wr_i && (ch_sel == 2'(g));
        assign wr_tpl = hit && (reg_idx == OFF_DRV_TPL);
        assign wr_scale = hit && (reg_idx == OFF_AMP_SCALE);
        assign wr_acc = hit && (reg_idx == OFF_RAM_ACC) && !busy[g];
        assign wr_amp = hit && (reg_idx == OFF_SAMPLE_AMP);

        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                driver_fault_monitor_disable_q[g] <= RST_DRIVER_FAULT_MONITOR_DISABLE;
                tristate_q[g] <= RST_TRISTATE;
                tpl_q[g] <= RST_TPL;
                user_q[g] <= 1'b0;
                step_q[g] <= STEP_PCT_E1;
            end else if (wr_tpl) begin
                driver_fault_monitor_disable_q[g] <= reg_wdata_i[DRIVER_FAULT_MONITOR_DISABLE_BIT];
                tristate_q[g] <= reg_wdata_i[TRISTATE_BIT];
                tpl_q[g] <= reg_wdata_i[TPL_LSB +: TPL_W];
                user_q[g] <= reg_wdata_i[TPL_LSB+2 +: 2] == TPL_USER_TOP;
                if (reg_wdata_i[TPL_LSB +: TPL_W] <= TPL_E1_120) begin
                    step_q[g] <= STEP_PCT_E1;
                end else begin
                    step_q[g] <= STEP_PCT_T1;
                end
            end
        end

        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                scale_q[g] <= RST_SCALE;
            end else if (wr_scale) begin
                scale_q[g] <= reg_wdata_i[SCALE_W-1:0];
            end
        end

        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                dir_q[g] <= 1'b0;
                ui_q[g] <= '0;
                samp_q[g] <= '0;
            end else if (wr_acc) begin
                dir_q[g] <= reg_wdata_i[DIR_BIT];
                ui_q[g] <= reg_wdata_i[UI_LSB +: UI_W];
                samp_q[g] <= reg_wdata_i[SAMP_LSB +: SAMP_W];
            end
        end

        // Read result wins over a software write in the same cycle
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                amp_q[g] <= RST_AMP;
            end else if (acc.rd_valid) begin
                amp_q[g] <= acc.rd_amp;
            end else if (wr_amp) begin
                amp_q[g] <= reg_wdata_i[AMP_W-1:0];
            end
        end

        // Launch takes the fields from the same write
        assign acc.launch = wr_acc && reg_wdata_i[LAUNCH_BIT];
        assign acc.dir_rd = reg_wdata_i[DIR_BIT];
        assign acc.ui = reg_wdata_i[UI_LSB +: UI_W];
        assign acc.samp = reg_wdata_i[SAMP_LSB +: SAMP_W];
        assign acc.wr_amp = amp_q[g];
        assign busy[g] = acc.busy;

        ttc_access_seq u_seq (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .acc(acc.seq)
        );

        ttc_template_ram u_ram (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .we_i(acc.ram_we),
            .re_i(acc.ram_re),
            .addr_i(acc.ram_addr),
            .wdata_i(acc.ram_wdata),
            .rdata_o(acc.ram_rdata)
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read-back; launch bit reads one while the access runs
    always_comb begin
        rdata_d = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            if (ch_sel == 2'(c)) begin
                unique case (reg_idx)
                    OFF_DRV_TPL: rdata_d = {2'b00, driver_fault_monitor_disable_q[c], tristate_q[c], tpl_q[c]};
                    OFF_AMP_SCALE: rdata_d = {2'b00, scale_q[c]};
                    OFF_RAM_ACC: rdata_d = {busy[c], dir_q[c], ui_q[c], samp_q[c]};
                    OFF_SAMPLE_AMP: rdata_d = {1'b0, amp_q[c]};
                    default: rdata_d = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
        end else if (reg_rd_i) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            access_busy_o <= '0;
        end else begin
            access_busy_o <= busy;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign driver_fault_monitor_disable_o = driver_fault_monitor_disable_q;
    assign line_driver_tristate_o = tristate_q;
    assign tx_template_select_o = tpl_q;
    assign user_waveform_sel_o = user_q;
    assign pulse_amplitude_scale_o = scale_q;
    assign scale_step_pct_o = step_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    dfm_bit_write_a: assert property (reg_wr_i && ch_sel == 2'd0 && reg_idx == OFF_DRV_TPL
        |=> driver_fault_monitor_disable_o[0] == $past(reg_wdata_i[DRIVER_FAULT_MONITOR_DISABLE_BIT]))
        else $error("monitor disable bit not taken");
    tristate_write_a: assert property (reg_wr_i && ch_sel == 2'd0 && reg_idx == OFF_DRV_TPL
        |=> line_driver_tristate_o[0] == $past(reg_wdata_i[TRISTATE_BIT]))
        else $error("tristate bit not taken");
    user_select_a: assert property (user_waveform_sel_o[0] == (tx_template_select_o[0][3:2] == 2'b11))
        else $error("user waveform select disagrees with template");
    scale_write_a: assert property (reg_wr_i && ch_sel == 2'd0 && reg_idx == OFF_AMP_SCALE
        |=> pulse_amplitude_scale_o[0] == $past(reg_wdata_i[5:0]))
        else $error("scale field not taken");
    step_e1_a: assert property (tx_template_select_o[0] <= 4'h1 |-> scale_step_pct_o[0] == 2'd3)
        else $error("E1 step size wrong");
    step_t1_a: assert property (tx_template_select_o[0] > 4'h1 |-> scale_step_pct_o[0] == 2'd2)
        else $error("T1 step size wrong");
    access_busy_a: assert property (g_ch[0].acc.launch |=> busy[0] ##1 busy[0] ##1 !busy[0])
        else $error("access length wrong");
    readback_amp_a: assert property (g_ch[0].acc.rd_valid |=> amp_q[0] == $past(g_ch[0].acc.rd_amp))
        else $error("read result not stored");

    write_cov_c: cover property (g_ch[0].acc.launch && !reg_wdata_i[DIR_BIT]);
    read_cov_c: cover property (g_ch[0].acc.rd_valid);
    user_cov_c: cover property (user_waveform_sel_o[0]);

endmodule

// *** verification/tb_top.sv ***
// Self-checking bench of the transmit template configuration bank.
// Assumes the bank is driven directly through its control port, no partner.
`timescale 1ns/100ps
module tb_top;
    import ttc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [ADDR_W-1:0] reg_addr_i = '0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [DATA_W-1:0] reg_wdata_i = '0;
    logic [DATA_W-1:0] reg_rdata_o;
    logic [NUM_CH-1:0] driver_fault_monitor_disable, tristate, user_sel, busy;
    logic [NUM_CH-1:0][TPL_W-1:0] tpl;
    logic [NUM_CH-1:0][SCALE_W-1:0] scale;
    logic [NUM_CH-1:0][1:0] step;
    logic [7:0] exp_q[$];
    logic rd_seen = 1'b0;
    logic [6:0] mem [64];
    int error_cnt = 0;
    int comparisons = 0;

    always #50 clk_i = ~clk_i;

    ttc_tx_template_cfg #(.NUM_CH(NUM_CH)) DUT (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o),
        .driver_fault_monitor_disable_o(driver_fault_monitor_disable),
        .line_driver_tristate_o(tristate),
        .tx_template_select_o(tpl),
        .user_waveform_sel_o(user_sel),
        .pulse_amplitude_scale_o(scale),
        .scale_step_pct_o(step),
        .access_busy_o(busy)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Compare tasks and verdict
    task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: output %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: read data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        if (exp_q.size() != 0) error_cnt++;
        $display("Counts: %0d mismatches in %0d comparisons", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Read monitor: data settles after the edge that took the strobe
    always @(posedge clk_i) rd_seen <= reg_rd_i;

    always @(negedge clk_i) begin
        if (rd_seen === 1'b1) begin
            if (exp_q.size() == 0) begin
                error_cnt++;
                $display("Error at %0t: read without expectation", $time);
            end else begin
                cmp_rd(reg_rdata_o, exp_q.pop_front());
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control port drivers
    task automatic op(input logic wr, input logic rd, input logic [1:0] ch, input logic [5:0] off,
                      input logic [7:0] d, input logic [7:0] e);
        @(posedge clk_i);
        reg_wr_i <= wr;
        reg_rd_i <= rd;
        reg_addr_i <= {ch, off};
        reg_wdata_i <= d;
        if (rd) exp_q.push_back(e);
    endtask

    task automatic idle();
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
    endtask

    task automatic wr(input logic [1:0] ch, input logic [5:0] off, input logic [7:0] d);
        op(1'b1, 1'b0, ch, off, d, 8'h00);
        idle();
    endtask

    task automatic rd(input logic [1:0] ch, input logic [5:0] off, input logic [7:0] e);
        op(1'b0, 1'b1, ch, off, 8'h00, e);
        idle();
    endtask

    task automatic wait_done(input logic [1:0] ch);
        logic saw;
        saw = 1'b0;
        for (int n = 0; n < 20; n++) begin
            @(negedge clk_i);
            if (busy[ch] === 1'b1) saw = 1'b1;
            else if (saw) break;
        end
        cmp_out({7'h00, saw}, 8'h01);
        cmp_out({7'h00, busy[ch]}, 8'h00);
    endtask

    task automatic acc(input logic [1:0] ch, input logic dir, input logic [5:0] a, input logic [6:0] amp);
        if (!dir) wr(ch, OFF_SAMPLE_AMP, {1'b0, amp});
        wr(ch, OFF_RAM_ACC, {1'b1, dir, a});
        wait_done(ch);
        rd(ch, OFF_RAM_ACC, {1'b0, dir, a});
        if (dir) rd(ch, OFF_SAMPLE_AMP, {1'b0, amp});
    endtask

    task automatic reset_check();
        // Let the last read land and be checked before reset clears it
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(negedge clk_i);
        for (int c = 0; c < NUM_CH; c++) begin
            cmp_out({7'h00, driver_fault_monitor_disable[c]}, 8'h00);
            cmp_out({7'h00, tristate[c]}, 8'h01);
            cmp_out({4'h0, tpl[c]}, 8'h00);
            cmp_out({7'h00, user_sel[c]}, 8'h00);
            cmp_out({2'b00, scale[c]}, 8'h21);
            cmp_out({6'h00, step[c]}, 8'h03);
            cmp_out({7'h00, busy[c]}, 8'h00);
            rd(2'(c), OFF_DRV_TPL, 8'h10);
            rd(2'(c), OFF_AMP_SCALE, 8'h21);
            rd(2'(c), OFF_RAM_ACC, 8'h00);
            rd(2'(c), OFF_SAMPLE_AMP, 8'h00);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] d;
        logic [5:0] s;
        void'($urandom(56));
        reset_check();
        // Every template code with random monitor and tristate bits
        for (int c = 0; c < NUM_CH; c++) begin
            for (int code = 0; code < 16; code++) begin
                d = {2'b00, 2'($urandom), 4'(code)};
                wr(2'(c), OFF_DRV_TPL, d);
                @(negedge clk_i);
                cmp_out({7'h00, driver_fault_monitor_disable[c]}, {7'h00, d[5]});
                cmp_out({7'h00, tristate[c]}, {7'h00, d[4]});
                cmp_out({4'h0, tpl[c]}, {4'h0, d[3:0]});
                cmp_out({7'h00, user_sel[c]}, {7'h00, d[3] & d[2]});
                cmp_out({6'h00, step[c]}, (code < 2) ? 8'h03 : 8'h02);
                rd(2'(c), OFF_DRV_TPL, d);
            end
            for (int k = 0; k < 5; k++) begin
                s = (k == 0) ? 6'h36 : (k == 1) ? 6'h21 : (k == 2) ? 6'h00 : (k == 3) ? 6'h3f : 6'($urandom);
                wr(2'(c), OFF_AMP_SCALE, {2'($urandom), s});
                @(negedge clk_i);
                cmp_out({2'b00, scale[c]}, {2'b00, s});
                rd(2'(c), OFF_AMP_SCALE, {2'b00, s});
            end
        end
        // Unmapped offsets
        wr(2'd0, 6'h07, 8'hff);
        rd(2'd0, 6'h07, 8'h00);
        rd(2'd1, 6'h3f, 8'h00);
        // Indirect writes across the address corners, then read back
        for (int i = 0; i < 8; i++) begin
            mem[i * 9] = 7'($urandom);
            acc(2'd0, 1'b0, 6'(i * 9), mem[i * 9]);
        end
        acc(2'd3, 1'b0, 6'd63, ~mem[63]);
        for (int i = 0; i < 8; i++) acc(2'd0, 1'b1, 6'(i * 9), mem[i * 9]);
        acc(2'd3, 1'b1, 6'd63, ~mem[63]);
        // Launch, then a refused write beside a read while busy
        wr(2'd0, OFF_SAMPLE_AMP, 8'h5a);
        op(1'b1, 1'b0, 2'd0, OFF_RAM_ACC, 8'haa, 8'h00);
        op(1'b1, 1'b1, 2'd0, OFF_RAM_ACC, 8'hc5, 8'haa);
        idle();
        wait_done(2'd0);
        rd(2'd0, OFF_RAM_ACC, 8'h2a);
        acc(2'd0, 1'b1, 6'h2a, 7'h5a);
        // Reset after the last access has finished restores defaults
        reset_check();
        repeat (4) @(posedge clk_i);
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        final_report();
    end
endmodule
